// [hw/nand_tree_pkg.sv]
// Constants shared by the board-connectivity test chain and its wrapper.
package nand_tree_pkg;

    // =========================================================================
    // Strap decode
    // =========================================================================
    localparam int unsigned STRAP_W = 5;
    // Mode strap code that selects the board-connectivity test.
    localparam logic [4:0] TREE_MODE_CODE = 5'h04;
    // Strap code held before the first sample after reset.
    localparam logic [4:0] STRAP_RESET_VAL = 5'h00;

    // =========================================================================
    // Chain layout
    // =========================================================================
    localparam int unsigned CHAIN_LEN = 34;
    // Constant operand of the first stage.
    localparam logic CHAIN_SEED = 1'b1;
    // Chain positions, zero based, in test order.
    localparam int unsigned POS_SECOND_IND = 0;
    localparam int unsigned POS_FIRST_IND = 1;
    localparam int unsigned POS_TXD_LO = 2;
    localparam int unsigned POS_TX_ER = 10;
    localparam int unsigned POS_GTX_CLK = 11;
    localparam int unsigned POS_TX_EN = 12;
    localparam int unsigned POS_RXD_HI = 13;
    localparam int unsigned POS_TXC = 17;
    localparam int unsigned POS_TX_CTL = 18;
    localparam int unsigned POS_RXD_LO = 19;
    localparam int unsigned POS_RX_DV = 23;
    localparam int unsigned POS_RX_ER = 24;
    localparam int unsigned POS_RX_CLK = 25;
    localparam int unsigned POS_CRS = 26;
    localparam int unsigned POS_COL = 27;
    localparam int unsigned POS_RX_CTL = 28;
    localparam int unsigned POS_RXC = 29;
    localparam int unsigned POS_INT_WAKE = 30;
    localparam int unsigned POS_MDC = 31;
    localparam int unsigned POS_MDIO = 32;
    localparam int unsigned POS_TX_CLK = 33;

    // =========================================================================
    // Output values after reset
    // =========================================================================
    localparam logic TREE_OUT_RESET = 1'b0;
    localparam logic TREE_OE_N_RESET = 1'b1;
    localparam logic TEST_MODE_RESET = 1'b0;
    // Clock-output enable strap copy held before the first sample.
    localparam logic CLK_OE_STRAP_RESET = 1'b0;

endpackage

// [hw/nand_chain_if.sv]
// Interface carrying the chain stage inputs and the chain result.
`timescale 1ns/1ps
`default_nettype none

interface nand_chain_if;
    // Pad levels in chain order, bit 0 is the first stage.
    logic [nand_tree_pkg::CHAIN_LEN-1:0] stage_in;
    // Output of the last stage.
    logic result;

    modport chain (
        input stage_in,
        output result
    );
    modport user (
        output stage_in,
        input result
    );
endinterface

`default_nettype wire

// [hw/nand_chain.sv]
// Combinational series chain of two-input NAND stages.
`timescale 1ns/1ps
`default_nettype none

module nand_chain (
    nand_chain_if.chain bus
);
    // =========================================================================
    // Chain
    // =========================================================================
    logic [nand_tree_pkg::CHAIN_LEN:0] link;

    assign link[0] = nand_tree_pkg::CHAIN_SEED;

    // Each stage NANDs its pin with the previous stage; every stage inverts,
    // so the polarity seen at the end depends on the distance to the end.
    genvar g;
    generate
        for (g = 0; g < nand_tree_pkg::CHAIN_LEN; g = g + 1) begin : g_stage
            assign link[g+1] = ~(bus.stage_in[g] & link[g]);
        end
    endgenerate

    assign bus.result = link[nand_tree_pkg::CHAIN_LEN];

endmodule

`default_nettype wire

// [hw/nand_tree_parametric_test.sv]
// Board-connectivity test wrapper: strap capture, pin chain and output drive.
//
// Notes on behaviour
// - Test mode only when straps read 00100.
// - Each stage NANDs pin with previous; seed one.
// - Chain runs indicator pins through to transmit clock.
// - Output follows tested pin, direct or inverted.
// - Result on reference clock pin, strap enables.
`timescale 1ns/1ps
`default_nettype none

// =============================================================================
// Overview
// =============================================================================
// After the asynchronous reset lets go, the first enabled clock edge reads the
// five mode straps and the clock-output enable strap together. That single
// sample decides the mode until the next reset. Later strap movement is
// ignored, so a board whose strap resistors are shared with live signals
// cannot flip the mode once the pins start toggling.
//
// In test mode the 34 chained pad levels feed a ripple of NAND stages. The
// ripple is purely combinational and settles well inside one 50 ns period for
// any realistic stage delay. That is why the result can be retimed by a single
// flop without any multicycle allowance.
//
// The output pad inverts the last stage. With the first chain position
// counted as one, every odd position then shows up inverted at the pin and
// every even position shows up direct.
//
// Outside test mode the result is forced low and the pin enable stays off, so
// the reference clock logic elsewhere keeps the pin to itself and the chained
// pins keep their normal functions.
//
// Limitations: the block does not police the tester's pin pattern. A pattern
// that breaks the one-pin-at-a-time convention simply gives a chain value that
// no single pin can be blamed for.
//
// The clock enable freezes both the strap sample and the output flops. Holding
// the enable low after reset therefore delays the strap read, and the straps
// must still be steady at the first enabled edge.
//
// The strap code is echoed on its own output so that board test software can
// confirm which mode the part believes it is in.

module nand_tree_parametric_test (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    input wire logic [4:0] mode_strap_in,
    input wire logic clock_output_enable_strap_in,
    input wire logic second_indicator_pin_in,
    input wire logic first_indicator_wake_pin_in,
    input wire logic [7:0] txd_in,
    input wire logic tx_er_in,
    input wire logic gtx_clk_in,
    input wire logic tx_en_in,
    input wire logic [7:0] rxd_in,
    input wire logic txc_in,
    input wire logic tx_ctl_in,
    input wire logic rx_dv_in,
    input wire logic rx_er_in,
    input wire logic rx_clk_in,
    input wire logic crs_in,
    input wire logic col_in,
    input wire logic rx_ctl_in,
    input wire logic rxc_in,
    input wire logic interrupt_wake_pin_in,
    input wire logic mdc_in,
    input wire logic mdio_in,
    input wire logic tx_clk_in,
    output logic reference_clock_tree_output_out,
    output logic reference_clock_tree_oe_n_out,
    output logic test_mode_out,
    output logic [4:0] strap_code_out
);

    // =========================================================================
    // Strap sampling sequence
    // =========================================================================
    // The straps are read by a clocked process after reset release, never by
    // the asynchronous reset itself, so the reset only loads constants.
    typedef enum logic [1:0] {
        ST_SAMPLE,
        ST_NORMAL,
        ST_TREE
    } mode_state_e;

    mode_state_e state_q;
    mode_state_e state_d;
    logic [4:0] strap_q;
    logic [4:0] strap_d;
    logic clk_oe_strap_q;
    logic clk_oe_strap_d;

    // Decode of the freshly sampled straps.
    logic code_selects_tree;
    assign code_selects_tree = (mode_strap_in == nand_tree_pkg::TREE_MODE_CODE);

    // Next-state choice: sampled once, then held until the next reset.
    always_comb begin
        state_d = state_q;
        strap_d = strap_q;
        clk_oe_strap_d = clk_oe_strap_q;
        case (state_q)
            ST_SAMPLE: begin
                strap_d = mode_strap_in;
                clk_oe_strap_d = clock_output_enable_strap_in;
                if (code_selects_tree) begin
                    state_d = ST_TREE;
                end else begin
                    state_d = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                state_d = ST_NORMAL;
            end
            ST_TREE: begin
                state_d = ST_TREE;
            end
            default: begin
                state_d = ST_SAMPLE;
            end
        endcase
    end

    // Mode register; the clock enable freezes the whole sequence.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_SAMPLE;
            strap_q <= nand_tree_pkg::STRAP_RESET_VAL;
            clk_oe_strap_q <= nand_tree_pkg::CLK_OE_STRAP_RESET;
        end else if (clk_en_in) begin
            state_q <= state_d;
            strap_q <= strap_d;
            clk_oe_strap_q <= clk_oe_strap_d;
        end
    end

    // =========================================================================
    // Chain input ordering
    // =========================================================================
    nand_chain_if chain_bus ();

    assign chain_bus.stage_in[nand_tree_pkg::POS_SECOND_IND] = second_indicator_pin_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_FIRST_IND] = first_indicator_wake_pin_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_TXD_LO +: 8] = txd_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_TX_ER] = tx_er_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_GTX_CLK] = gtx_clk_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_TX_EN] = tx_en_in;
    // Upper receive bits run 7 down to 4.
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_HI] = rxd_in[7];
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_HI + 1] = rxd_in[6];
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_HI + 2] = rxd_in[5];
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_HI + 3] = rxd_in[4];
    assign chain_bus.stage_in[nand_tree_pkg::POS_TXC] = txc_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_TX_CTL] = tx_ctl_in;
    // Lower receive bits run 3 down to 0.
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_LO] = rxd_in[3];
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_LO + 1] = rxd_in[2];
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_LO + 2] = rxd_in[1];
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXD_LO + 3] = rxd_in[0];
    assign chain_bus.stage_in[nand_tree_pkg::POS_RX_DV] = rx_dv_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_RX_ER] = rx_er_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_RX_CLK] = rx_clk_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_CRS] = crs_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_COL] = col_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_RX_CTL] = rx_ctl_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_RXC] = rxc_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_INT_WAKE] = interrupt_wake_pin_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_MDC] = mdc_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_MDIO] = mdio_in;
    assign chain_bus.stage_in[nand_tree_pkg::POS_TX_CLK] = tx_clk_in;

    nand_chain u_chain (
        .bus(chain_bus.chain)
    );

    // =========================================================================
    // Output drive
    // =========================================================================
    // The tester is expected to set one pin at a time with the rest held at
    // fixed levels; the chain itself makes no check of that.
    logic tree_active;
    logic drive_enable;
    logic tree_result;
    logic tree_out_d;
    logic tree_oe_n_d;

    assign tree_active = (state_q == ST_TREE);
    assign drive_enable = tree_active & clk_oe_strap_q;
    assign tree_result = ~chain_bus.result;
    assign tree_out_d = tree_active ? tree_result : nand_tree_pkg::TREE_OUT_RESET;
    assign tree_oe_n_d = ~drive_enable;

    // The result is retimed once so that every output leaves a flip-flop;
    // this costs one clock of latency, which a slow tester does not notice.
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reference_clock_tree_output_out <= nand_tree_pkg::TREE_OUT_RESET;
            reference_clock_tree_oe_n_out <= nand_tree_pkg::TREE_OE_N_RESET;
            test_mode_out <= nand_tree_pkg::TEST_MODE_RESET;
            strap_code_out <= nand_tree_pkg::STRAP_RESET_VAL;
        end else if (clk_en_in) begin
            reference_clock_tree_output_out <= tree_out_d;
            reference_clock_tree_oe_n_out <= tree_oe_n_d;
            test_mode_out <= tree_active;
            strap_code_out <= strap_q;
        end
    end

endmodule

`default_nettype wire

// [test/nand_tree_monitor.sv]
// Checker for the board-connectivity test wrapper, bound to its ports.
`timescale 1ns/1ps
`default_nettype none
module nand_tree_monitor (
    input wire logic clk_sys_in, arst_n_in, clk_en_in,
    input wire logic [4:0] mode_strap_in,
    input wire logic clock_output_enable_strap_in, second_indicator_pin_in,
    input wire logic first_indicator_wake_pin_in, tx_er_in, gtx_clk_in, tx_en_in,
    input wire logic [7:0] txd_in, rxd_in,
    input wire logic txc_in, tx_ctl_in, rx_dv_in, rx_er_in, rx_clk_in, crs_in, col_in,
    input wire logic rx_ctl_in, rxc_in, interrupt_wake_pin_in, mdc_in, mdio_in, tx_clk_in,
    input wire logic reference_clock_tree_output_out, reference_clock_tree_oe_n_out,
    input wire logic test_mode_out,
    input wire logic [4:0] strap_code_out
);
    // =====================================================================
    // Pads gathered in chain order, bit 0 is the first stage.
    logic [33:0] pins;
    logic tout, oen, tm;
    assign pins = {tx_clk_in, mdio_in, mdc_in, interrupt_wake_pin_in, rxc_in, rx_ctl_in, col_in,
        crs_in, rx_clk_in, rx_er_in, rx_dv_in, rxd_in[0], rxd_in[1], rxd_in[2], rxd_in[3],
        tx_ctl_in, txc_in, rxd_in[4], rxd_in[5], rxd_in[6], rxd_in[7], tx_en_in, gtx_clk_in,
        tx_er_in, txd_in, first_indicator_wake_pin_in, second_indicator_pin_in};
    assign tout = reference_clock_tree_output_out;
    assign oen = reference_clock_tree_oe_n_out;
    assign tm = test_mode_out;
    // Reference chain, built stage by stage from the constant seed.
    function automatic logic chain_f(input logic [33:0] p);
        logic s = 1'b1;
        for (int i = 0; i < 34; i++) s = ~(s & p[i]);
        return s;
    endfunction
    // =====================================================================
    // Properties
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    sequence low_below_s;
        test_mode_out && clk_en_in && pins[32:0] == 33'h0;
    endsequence
    sequence high_above_s;
        test_mode_out && clk_en_in && pins[33:1] == 33'h1ffffffff;
    endsequence
    // Pins taken by an enabled edge in test mode, still in test mode one edge on.
    sequence chain_s;
        (test_mode_out && clk_en_in) ##1 tm;
    endsequence
    mode_code_a: assert property (test_mode_out |-> strap_code_out == 5'h04)
        else $error("test mode entered with another strap code");
    mode_hold_a: assert property ($past(tm) |-> tm && $stable(strap_code_out))
        else $error("latched mode changed without reset");
    oe_mode_a: assert property (!oen |-> test_mode_out)
        else $error("tree output driven outside test mode");
    normal_quiet_a: assert property (!test_mode_out |-> !tout && oen)
        else $error("tree output active in normal mode");
    chain_value_a: assert property (chain_s |-> tout == !$past(chain_f(pins)))
        else $error("tree output differs from chain");
    last_direct_a: assert property (low_below_s ##1 tm |-> tout == $past(pins[33]))
        else $error("last pin not direct");
    first_inverted_a: assert property (high_above_s ##1 tm |-> tout == !$past(pins[0]))
        else $error("first pin not inverted");
endmodule
bind nand_tree_parametric_test nand_tree_monitor nand_tree_monitor_inst (.clk_sys_in, .arst_n_in,
    .clk_en_in, .mode_strap_in, .clock_output_enable_strap_in, .second_indicator_pin_in,
    .first_indicator_wake_pin_in, .txd_in, .tx_er_in, .gtx_clk_in, .tx_en_in, .rxd_in, .txc_in,
    .tx_ctl_in, .rx_dv_in, .rx_er_in, .rx_clk_in, .crs_in, .col_in, .rx_ctl_in, .rxc_in,
    .interrupt_wake_pin_in, .mdc_in, .mdio_in, .tx_clk_in, .reference_clock_tree_output_out,
    .reference_clock_tree_oe_n_out, .test_mode_out, .strap_code_out);
`default_nettype wire

// [test/board_tester.sv]
// Board tester model: walks one chain pin while fixing all the others.
`timescale 1ns/1ps
`default_nettype none
module board_tester (
    input wire logic [5:0] pos_in,
    input wire logic level_in,
    output logic [33:0] pins_out
);
    // =====================================================================
    // Pin pattern; low below keeps a one arriving at the tested stage.
    // single pin walk
    always_comb begin
        for (int i = 0; i < 34; i++) begin
            pins_out[i] = (i < pos_in) ? 1'b0 : ((i > pos_in) ? 1'b1 : level_in);
        end
    end
endmodule
`default_nettype wire

// [test/nand_tree_parametric_test_test.sv]
// Self-checking bench for the board-connectivity test wrapper.
`timescale 1ns/1ps
`default_nettype none
module nand_tree_parametric_test_test;
    logic clk_sys_in, arst_n_in, clk_en_in, oe_strap, lvl, tree_out, oe_n, tmode;
    logic [4:0] strap, code;
    logic [5:0] pos;
    logic [33:0] pins;
    int fail_count = 0;
    int n_checks = 0;
    // =====================================================================
    // Clock and watchdog; the run is near 860 cycles, 200 us is ample.
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
    board_tester board_tester_inst (.pos_in(pos), .level_in(lvl), .pins_out(pins));
    nand_tree_parametric_test nand_tree_parametric_test_inst (.clk_sys_in, .arst_n_in,
        .clk_en_in, .mode_strap_in(strap), .clock_output_enable_strap_in(oe_strap),
        .second_indicator_pin_in(pins[0]), .first_indicator_wake_pin_in(pins[1]),
        .txd_in(pins[9:2]), .tx_er_in(pins[10]), .gtx_clk_in(pins[11]), .tx_en_in(pins[12]),
        .rxd_in({pins[13], pins[14], pins[15], pins[16], pins[19], pins[20], pins[21], pins[22]}),
        .txc_in(pins[17]), .tx_ctl_in(pins[18]), .rx_dv_in(pins[23]), .rx_er_in(pins[24]),
        .rx_clk_in(pins[25]), .crs_in(pins[26]), .col_in(pins[27]), .rx_ctl_in(pins[28]),
        .rxc_in(pins[29]), .interrupt_wake_pin_in(pins[30]), .mdc_in(pins[31]),
        .mdio_in(pins[32]), .tx_clk_in(pins[33]), .reference_clock_tree_output_out(tree_out),
        .reference_clock_tree_oe_n_out(oe_n), .test_mode_out(tmode), .strap_code_out(code));
    // =====================================================================
    // Shared tasks; inputs move only at the falling edge.
    task automatic chk(input string n, input logic [4:0] e, input logic [4:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step();
        @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask
    // Straps are steady through reset so the first edge after it takes them.
    task automatic start(input logic [4:0] c, input logic oe);
        arst_n_in = 1'b0;
        strap = c;
        oe_strap = oe;
        repeat (20) step();
        arst_n_in = 1'b1;
        repeat (3) step();
    endtask
    // The result is retimed once, so it is read one edge after the pin moves.
    // Counted from one, odd positions show up inverted at the pin.
    task automatic walk(input int p, input logic v);
        logic e;
        pos = 6'(p);
        lvl = v;
        e = (p % 2 == 0) ? ~v : v;
        step();
        chk("tree output", 5'(e), 5'(tree_out));
    endtask
    task automatic test_tree();
        start(5'h04, 1'b1);
        chk("test mode", 5'h01, 5'(tmode));
        chk("strap code", 5'h04, code);
        chk("output enable", 5'h00, 5'(oe_n));
        for (int p = 0; p < 34; p++) begin
            walk(p, 1'b0);
            walk(p, 1'b1);
        end
        $display("test tree_walk done");
    endtask
    task automatic test_strap_off();
        start(5'h04, 1'b0);
        chk("test mode", 5'h01, 5'(tmode));
        chk("output enable", 5'h01, 5'(oe_n));
        walk(0, 1'b1);
        $display("test strap_off done");
    endtask
    // Clock enable low must hold the registered result; first pin is still tested.
    task automatic test_freeze();
        clk_en_in = 1'b0;
        lvl = 1'b0;
        step();
        chk("frozen output", 5'h00, 5'(tree_out));
        clk_en_in = 1'b1;
        step();
        chk("resumed output", 5'h01, 5'(tree_out));
        $display("test freeze done");
    endtask
    task automatic test_other_codes();
        for (int c = 0; c < 32; c++) begin
            if (c != 4) begin
                start(5'(c), 1'b1);
                chk("test mode", 5'h00, 5'(tmode));
                chk("strap code", 5'(c), code);
                chk("output enable", 5'h01, 5'(oe_n));
                lvl = ~lvl;
                step();
                chk("idle output", 5'h00, 5'(tree_out));
            end
        end
        $display("test other_codes done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        clk_en_in = 1'b1;
        pos = 6'h00;
        lvl = 1'b0;
        test_tree();
        test_strap_off();
        test_freeze();
        test_other_codes();
        complete_run();
    end
endmodule
`default_nettype wire
